// ===== src/ioadi_card.sv
// Our own choices: the register offsets and the plain strobed port.
`include "ioadi_regs.svh"
`default_nettype none
module ioadi_card (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [9:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  output logic io_hit_out,
  input wire logic [7:0] base_select_switch_in,
  input wire logic irq_level_jumper_x_in,
  input wire logic [2:0] irq_level_jumper_in,
  input wire logic gate_mode_jumper_in,
  input wire logic trigger_edge_jumper_in,
  input wire logic [7:0] isolated_input_in,
  output logic [7:0] relay_out,
  output logic [7:0] irq_lines_out,
  output logic [7:0] irq_lines_oe_out,
  output logic irq_out
);
  // ----------------------------------------
  // State and bus grouping
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] relay;
    logic [`IOADI_IRQ_BITS-1:0] stat;
    logic [`IOADI_IRQ_BITS-1:0] mask;
    logic [7:0] rdata;
    logic hit;
    logic [7:0] sw;
    logic sw_loaded;
  } ioadi_state_s;

  ioadi_state_s s_q;
  ioadi_state_s s_d;
  ioadi_pkg::ioadi_bus_s bus;
  ioadi_pkg::ioadi_jumper_s jmp;
  logic [7:0] inputs_sync;
  logic [7:0] sw_sync;
  logic [5:0] jmp_sync;
  logic [7:0] match_bits;
  logic sel;
  logic [1:0] ofs;
  logic edge_p;
  logic [`IOADI_IRQ_BITS-1:0] ev;
  logic [`IOADI_IRQ_BITS-1:0] clr;
  logic irq_level;
  logic [`IOADI_LVL_COUNT-1:0] lvl_dec;

  assign bus = '{addr: io_addr_in, wdata: io_wdata_in, wr: io_wr_in, rd: io_rd_in};

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  ioadi_sync #(.WIDTH(8)) u_sync_in (
    .clock_in(clock_in),
    .async_in(isolated_input_in),
    .sync_out(inputs_sync)
  );

  ioadi_sync #(.WIDTH(8)) u_sync_sw (
    .clock_in(clock_in),
    .async_in(base_select_switch_in),
    .sync_out(sw_sync)
  );

  ioadi_sync #(.WIDTH(6)) u_sync_jmp (
    .clock_in(clock_in),
    .async_in({irq_level_jumper_x_in, irq_level_jumper_in, gate_mode_jumper_in,
               trigger_edge_jumper_in}),
    .sync_out(jmp_sync)
  );

  assign jmp = ioadi_pkg::ioadi_jumper_s'(jmp_sync);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Switch bit 7 is position 1 (A9), bit 0 is position 8 (A2); 1 = off
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_match
      assign match_bits[k] = (bus.addr[k+2] == s_q.sw[k]);
    end
  endgenerate

  assign sel = s_q.sw_loaded & (&match_bits);
  assign ofs = bus.addr[1:0];

  // ----------------------------------------
  // Interrupt source
  // ----------------------------------------
  ioadi_edge u_edge (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .level_in(inputs_sync[`IOADI_IN_ZERO]),
    .falling_in(jmp.trigger_edge_jumper),
    .gate_on_in(jmp.gate_mode_jumper),
    .gate_level_in(inputs_sync[`IOADI_IN_FOUR]),
    .edge_out(edge_p)
  );

  // Overrun flags an edge that arrives while the edge flag still stands
  always_comb begin
    ev = '0;
    ev[`IOADI_IRQ_EDGE] = edge_p;
    ev[`IOADI_IRQ_OVR] = edge_p & s_q.stat[`IOADI_IRQ_EDGE];
  end

  always_comb begin
    clr = '0;
    if (sel && bus.wr && ofs == `IOADI_OFS_IRQ_STAT) begin
      clr = bus.wdata[`IOADI_IRQ_BITS-1:0];
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    s_d.rdata = 8'h00;
    // Switch setting captured once after reset release
    if (!s_q.sw_loaded) begin
      s_d.sw = sw_sync;
      s_d.sw_loaded = 1'b1;
    end
    // Writes; unused offsets change nothing
    if (sel && bus.wr) begin
      s_d.hit = 1'b1;
      case (ofs)
        `IOADI_OFS_RELAY: s_d.relay = bus.wdata;
        `IOADI_OFS_IRQ_MASK: s_d.mask = bus.wdata[`IOADI_IRQ_BITS-1:0];
        default: s_d.relay = s_q.relay;
      endcase
    end
    // Reads return data in the following cycle
    if (sel && bus.rd) begin
      s_d.hit = 1'b1;
      case (ofs)
        `IOADI_OFS_RELAY: s_d.rdata = s_q.relay;
        `IOADI_OFS_INPUT: s_d.rdata = inputs_sync;
        `IOADI_OFS_IRQ_STAT: s_d.rdata = {6'h00, s_q.stat};
        `IOADI_OFS_IRQ_MASK: s_d.rdata = {6'h00, s_q.mask};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    s_d.stat = (s_q.stat & ~clr) | ev;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s_q <= '{relay: `IOADI_RELAY_RESET, stat: `IOADI_IRQ_RESET, mask: `IOADI_IRQ_RESET,
               rdata: 8'h00, hit: 1'b0, sw: `IOADI_SW_DEFAULT, sw_loaded: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Interrupt routing
  // ----------------------------------------
  assign irq_level = |(s_q.stat & s_q.mask);

  // One-hot line select; X position drives nothing
  generate
    for (k = 0; k < `IOADI_LVL_COUNT; k++) begin : g_irq
      assign lvl_dec[k] = ~jmp.irq_level_jumper_x &
                          (jmp.irq_level_jumper == (`IOADI_LVL_W)'(k));
      assign irq_lines_oe_out[k] = lvl_dec[k];
      assign irq_lines_out[k] = lvl_dec[k] & irq_level;
    end
  endgenerate

  assign irq_out = irq_level & ~jmp.irq_level_jumper_x;
  assign relay_out = s_q.relay;
  assign io_rdata_out = s_q.rdata;
  assign io_hit_out = s_q.hit;
endmodule
`default_nettype wire

// ===== src/ioadi_regs.svh
`ifndef IOADI_REGS_SVH
`define IOADI_REGS_SVH
// ----------------------------------------
// Card address map and constants
// ----------------------------------------
`define IOADI_OFS_RELAY 2'h0
`define IOADI_OFS_INPUT 2'h1
`define IOADI_OFS_IRQ_STAT 2'h2
`define IOADI_OFS_IRQ_MASK 2'h3
`define IOADI_SW_DEFAULT 8'hC0
`define IOADI_RELAY_RESET 8'h00
`define IOADI_IRQ_BITS 2
`define IOADI_IRQ_EDGE 0
`define IOADI_IRQ_OVR 1
`define IOADI_IRQ_RESET 2'h0
`define IOADI_IN_ZERO 0
`define IOADI_IN_FOUR 4
`define IOADI_LVL_COUNT 8
`define IOADI_LVL_W 3
`define IOADI_LVL_NONE 3'h0
`endif

// ===== src/ioadi_pkg.sv
`default_nettype none
// ----------------------------------------
// Shared types
// ----------------------------------------
package ioadi_pkg;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ioadi_bus_s;

  typedef struct packed {
    logic irq_level_jumper_x;
    logic [2:0] irq_level_jumper;
    logic gate_mode_jumper;
    logic trigger_edge_jumper;
  } ioadi_jumper_s;

  typedef enum logic [1:0] {
    IOADI_EDGE_IDLE = 2'b00,
    IOADI_EDGE_SEEN = 2'b01
  } ioadi_edge_e;
endpackage
`default_nettype wire

// ===== src/ioadi_sync.sv
`include "ioadi_regs.svh"
`default_nettype none
// ----------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------
module ioadi_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_q;
  logic [WIDTH-1:0] sync_q;

  // Each bit passes two flip-flops
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // No reset, so a pin held high through reset gives no false edge after it
      always_ff @(posedge clock_in) begin
        stage_q[i] <= async_in[i];
        sync_q[i] <= stage_q[i];
      end
    end
  endgenerate

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== src/ioadi_edge.sv
`include "ioadi_regs.svh"
`default_nettype none
// ----------------------------------------
// Edge detector with polarity select and gate
// ----------------------------------------
module ioadi_edge (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic level_in,
  input wire logic falling_in,
  input wire logic gate_on_in,
  input wire logic gate_level_in,
  output logic edge_out
);
  typedef struct packed {
    logic prev;
    ioadi_pkg::ioadi_edge_e st;
    logic edge_p;
  } ioadi_edge_state_s;

  ioadi_edge_state_s s_q;
  ioadi_edge_state_s s_d;
  logic hit;

  // Pulse once per qualifying transition, never on a steady level
  always_comb begin
    s_d = s_q;
    hit = falling_in ? (s_q.prev & ~level_in) : (~s_q.prev & level_in);
    s_d.prev = level_in;
    s_d.edge_p = 1'b0;
    case (s_q.st)
      ioadi_pkg::IOADI_EDGE_IDLE: begin
        s_d.st = ioadi_pkg::IOADI_EDGE_SEEN;
      end
      ioadi_pkg::IOADI_EDGE_SEEN: begin
        s_d.edge_p = hit & (~gate_on_in | gate_level_in);
      end
      default: begin
        s_d.st = ioadi_pkg::IOADI_EDGE_IDLE;
      end
    endcase
  end

  // First cycle after reset only learns the level
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s_q <= '{prev: 1'b0, st: ioadi_pkg::IOADI_EDGE_IDLE, edge_p: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign edge_out = s_q.edge_p;
endmodule
`default_nettype wire

// ===== bench/ioadi_card_sva.sv
`default_nettype none
// ----------------------------------------
// Port checker for the card
// ----------------------------------------
module ioadi_card_sva (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [9:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_hit_out,
  input wire logic [7:0] base_select_switch_in,
  input wire logic irq_level_jumper_x_in,
  input wire logic [2:0] irq_level_jumper_in,
  input wire logic [7:0] relay_out,
  input wire logic [7:0] irq_lines_oe_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic [2:0] age_q;
  logic req;
  logic hit;
  // Cycles since reset, saturating; decode is off until switches are sampled
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  // Decoded host cycle
  assign req = io_wr_in | io_rd_in;
  assign hit = req && io_addr_in[9:2] == base_select_switch_in && age_q > 3'h3;
  AST_MISS: assert property (req && io_addr_in[9:2] != base_select_switch_in |=>
    !io_hit_out) else $error("foreign hit");
  AST_HIT: assert property (hit |=> io_hit_out) else $error("no answer");
  AST_RD_IDLE: assert property (!io_rd_in |=> io_rdata_out == 8'h00)
    else $error("stray read data");
  AST_RELAY_KEEP: assert property (!io_wr_in |=> $stable(relay_out))
    else $error("relay moved");
  AST_RELAY_WR: assert property (hit && io_wr_in && io_addr_in[1:0] == 2'h0 |=>
    relay_out == $past(io_wdata_in)) else $error("relay write lost");
  AST_RD_RELAY: assert property (hit && io_rd_in && io_addr_in[1:0] == 2'h0 |=>
    io_rdata_out == relay_out) else $error("relay readback");
  AST_X_QUIET: assert property (irq_level_jumper_x_in[*4] |->
    irq_lines_oe_out == 8'h00 && !irq_out) else $error("irq while off");
  AST_ONE_HOT: assert property ((!irq_level_jumper_x_in && $stable(irq_level_jumper_in))[*4]
    |-> irq_lines_oe_out == 8'h01 << irq_level_jumper_in) else $error("wrong irq line");
endmodule
bind ioadi_card ioadi_card_sva i_ioadi_card_sva (.*);
`default_nettype wire

// ===== bench/ioadi_host.sv
`default_nettype none
// ----------------------------------------
// Host bus master model
// ----------------------------------------
module ioadi_host (
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  output var ioadi_pkg::ioadi_bus_s bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_out = '0;
  // One-cycle I/O write; address scrambled once released
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clock_in);
    bus_out <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    bus_out <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
  endtask
  // One-cycle I/O read; data taken in the following cycle
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge clock_in);
    bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    bus_out <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(posedge clock_in);
    v = rdata_in;
  endtask
endmodule
`default_nettype wire

// ===== bench/test_io_address_decode_and_input_interrupt.sv
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_io_address_decode_and_input_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic jx = 1'b0;
  logic gate = 1'b0;
  logic trig = 1'b0;
  logic [7:0] sw = 8'hC0;
  logic [2:0] lvl = 3'h5;
  logic irq;
  logic [7:0] din = 8'h00;
  logic [7:0] rdata, relay, lines, oe, d;
  ioadi_pkg::ioadi_bus_s bus;
  int err_count = 0;
  int checked = 0;
  // Rows: address, write data, expected relay state
  logic [25:0] rows [6] = '{{10'h300, 8'h5A, 8'h5A}, {10'h300, 8'hA5, 8'hA5},
    {10'h304, 8'hFF, 8'hA5}, {10'h2FC, 8'h00, 8'hA5}, {10'h301, 8'h33, 8'hA5},
    {10'h300, 8'hFF, 8'hFF}};
  always #4 clock_in = ~clock_in;
  ioadi_host i_ioadi_host (.clock_in(clock_in), .rdata_in(rdata), .bus_out(bus));
  ioadi_card i_ioadi_card (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .io_addr_in(bus.addr), .io_wdata_in(bus.wdata), .io_wr_in(bus.wr), .io_rd_in(bus.rd),
    .io_rdata_out(rdata), .io_hit_out(), .base_select_switch_in(sw),
    .irq_level_jumper_x_in(jx), .irq_level_jumper_in(lvl), .gate_mode_jumper_in(gate),
    .trigger_edge_jumper_in(trig), .isolated_input_in(din), .relay_out(relay),
    .irq_lines_out(lines), .irq_lines_oe_out(oe), .irq_out(irq));
  // Drive the isolated inputs and let them pass the synchronisers
  task automatic drive_in(input logic [7:0] v);
    @(posedge clock_in) din <= v;
    repeat (6) @(posedge clock_in);
  endtask
  // Clear both status bits and confirm the request drops
  task automatic clear_irq();
    i_ioadi_host.wr(10'h302, 8'h03);
    repeat (8) @(posedge clock_in);
    `CHK(irq, 1'b0)
    i_ioadi_host.rd(10'h302, d);
    `CHK(d, 8'h00)
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    `CHK(relay, 8'h00)
    foreach (rows[i]) begin
      i_ioadi_host.wr(rows[i][25:16], rows[i][15:8]);
      i_ioadi_host.rd(10'h300, d);
      `CHK(d, rows[i][7:0])
      `CHK(relay, rows[i][7:0])
    end
    drive_in(8'h96);
    i_ioadi_host.rd(10'h301, d);
    `CHK(d, 8'h96)
    i_ioadi_host.wr(10'h303, 8'h01);
    drive_in(8'h97);
    `CHK(irq, 1'b1)
    `CHK(lines & oe, 8'h20)
    clear_irq();
    @(posedge clock_in) trig <= 1'b1;
    drive_in(8'h96);
    `CHK(irq, 1'b1)
    clear_irq();
    @(posedge clock_in) begin
      gate <= 1'b1;
      trig <= 1'b0;
    end
    drive_in(8'h86);
    drive_in(8'h87);
    `CHK(irq, 1'b0)
    drive_in(8'h96);
    drive_in(8'h97);
    `CHK(irq, 1'b1)
    // Second edge before the clear also raises the overrun bit
    drive_in(8'h96);
    drive_in(8'h97);
    i_ioadi_host.rd(10'h302, d);
    `CHK(d, 8'h03)
    i_ioadi_host.rd(10'h303, d);
    `CHK(d, 8'h01)
    @(posedge clock_in) jx <= 1'b1;
    repeat (5) @(posedge clock_in);
    `CHK(irq, 1'b0)
    `CHK(oe, 8'h00)
    // Mid-run reset with base 004, another line and input zero held high
    @(posedge clock_in) begin
      sw <= 8'h01;
      lvl <= 3'h2;
      sys_rst_in <= 1'b1;
    end
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    jx <= 1'b0;
    repeat (5) @(posedge clock_in);
    `CHK(relay, 8'h00)
    `CHK(oe, 8'h04)
    i_ioadi_host.wr(10'h007, 8'h01);
    repeat (4) @(posedge clock_in);
    `CHK(irq, 1'b0)
    i_ioadi_host.wr(10'h004, 8'h3C);
    i_ioadi_host.rd(10'h004, d);
    `CHK(d, 8'h3C)
    `CHK(relay, 8'h3C)
    i_ioadi_host.rd(10'h300, d);
    `CHK(d, 8'h00)
    complete_run();
  end
  // Watchdog
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
